// >>> include/pec_link_if.sv
// Byte-level link between host end and device end.
// Assumes one shared sys_clk.
`timescale 1ns/1ps
interface pec_link_if;
    logic dn_valid;
    logic [7:0] dn_data;
    logic dn_alive;
    logic dn_last;
    logic dn_char_err;
    logic up_valid;
    logic up_ready;
    logic [7:0] up_data;
    logic up_last;

    modport device
    (
        input dn_valid, dn_data, dn_alive, dn_last, dn_char_err, up_ready,
        output up_valid, up_data, up_last
    );

    modport host
    (
        output dn_valid, dn_data, dn_alive, dn_last, dn_char_err, up_ready,
        input up_valid, up_data, up_last
    );
endinterface

// >>> include/pec_pkg.sv
// Shared constants and check function for both ends.
// Assumes byte-level traffic; framing lives elsewhere.
package pec_pkg;

    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = BYTE_W + 1;
    localparam int HOST_BUF_DEPTH = 16;
    localparam int HOST_PTR_W = 5;

    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [7:0] REFLECTED_CONST_A = 8'hb2;

    localparam logic [7:0] BROADCAST_WRITE_CMD = 8'h02;
    localparam logic [7:0] SINGLE_WRITE_CMD = 8'h04;
    localparam logic [7:0] BROADCAST_READ_CMD = 8'h03;
    localparam logic [7:0] SINGLE_DEVICE_READ_CMD = 8'h05;

    localparam logic [7:0] IDX_CMD = 8'h00;
    localparam logic [7:0] IDX_REG = 8'h01;
    localparam logic [7:0] IDX_DATA_LO = 8'h02;
    localparam logic [7:0] IDX_DATA_HI = 8'h03;
    localparam logic [7:0] IDX_MAX = 8'hff;

    localparam int CHECK_PEC_BIT = 0;
    localparam int CHECK_RST_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Fold one byte into the remainder, low bit first
    function automatic logic [7:0] crc_fold(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] r;
        r = crc ^ data;
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ REFLECTED_CONST_A) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic is_write_cmd(input logic [7:0] cmd);
        return (cmd == BROADCAST_WRITE_CMD) || (cmd == SINGLE_WRITE_CMD);
    endfunction

    function automatic logic is_read_cmd(input logic [7:0] cmd);
        return (cmd == BROADCAST_READ_CMD) || (cmd == SINGLE_DEVICE_READ_CMD);
    endfunction

endpackage

// >>> rtl/pec_device_end.sv
// Device end: packet check, alerts, read response.
// Assumes in-order bytes and one clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Response byte FIFO
module resp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
// Device end
module pec_device_end
(
    input wire logic sys_clk,
    input wire logic reset_n,
    pec_link_if.device link,
    input wire logic baud_lock,
    input wire logic mode_lock,
    input wire logic addr_load,
    input wire logic [7:0] addr_value,
    input wire logic clr_pec_alert,
    input wire logic clr_reset_alert,
    output logic [7:0] device_addr,
    output logic baud_detected,
    output logic rx_mode_detected,
    output logic pec_error_alert,
    output logic reset_occurred_alert,
    output logic check_done,
    output logic check_ok,
    output logic wr_exec,
    output logic rd_req,
    output logic [7:0] cmd_code,
    output logic [7:0] reg_addr,
    output logic [15:0] wr_data,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    output logic rsp_ready
);
    import pec_pkg::*;

    typedef enum logic [1:0] {TX_DATA, TX_CHECK, TX_PEC} tx_state_e;

    logic [7:0] crc_ff;
    logic [7:0] idx_ff;
    logic char_err_ff;
    logic [7:0] cmd_ff;
    logic [7:0] reg_ff;
    logic [15:0] data_ff;
    logic done_ff;
    logic ok_ff;
    logic wr_exec_ff;
    logic rd_req_ff;
    logic pec_alert_ff;
    logic rst_alert_ff;
    logic [7:0] addr_ff;
    logic baud_ff;
    logic mode_ff;
    logic pec_match;
    logic pkt_good;
    logic end_pkt;

    assign end_pkt = link.dn_valid && link.dn_last;
    assign pec_match = (link.dn_data == crc_ff);
    assign pkt_good = pec_match && !char_err_ff && !link.dn_char_err;

    ////////////////////////////////////////////////////////////////////////
    // Receive remainder and byte index
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            crc_ff <= CRC_INIT;
            idx_ff <= '0;
            char_err_ff <= 1'b0;
        end
        else if (end_pkt)
        begin
            crc_ff <= CRC_INIT;
            idx_ff <= '0;
            char_err_ff <= 1'b0;
        end
        else if (link.dn_valid)
        begin
            if (!link.dn_alive)
            begin
                crc_ff <= crc_fold(crc_ff, link.dn_data);
            end
            if (idx_ff != IDX_MAX)
            begin
                idx_ff <= idx_ff + 1'b1;
            end
            char_err_ff <= char_err_ff | link.dn_char_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command fields
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {cmd_ff, reg_ff, data_ff} <= '0;
        end
        else if (link.dn_valid && !link.dn_last && !link.dn_alive)
        begin
            unique case (idx_ff)
                IDX_CMD: cmd_ff <= link.dn_data;
                IDX_REG: reg_ff <= link.dn_data;
                IDX_DATA_LO: data_ff[7:0] <= link.dn_data;
                IDX_DATA_HI: data_ff[15:8] <= link.dn_data;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Check result and command outcome
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {done_ff, ok_ff, wr_exec_ff, rd_req_ff} <= '0;
        end
        else
        begin
            done_ff <= end_pkt;
            wr_exec_ff <= end_pkt && pkt_good && is_write_cmd(cmd_ff);
            rd_req_ff <= end_pkt && pkt_good && is_read_cmd(cmd_ff);
            if (end_pkt)
            begin
                ok_ff <= pkt_good;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alert flags; a set beats a clear
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pec_alert_ff <= 1'b0;
            rst_alert_ff <= 1'b1;
        end
        else
        begin
            if (end_pkt && !pec_match)
            begin
                pec_alert_ff <= 1'b1;
            end
            else if (clr_pec_alert)
            begin
                pec_alert_ff <= 1'b0;
            end
            if (clr_reset_alert)
            begin
                rst_alert_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and detection state
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_ff <= '0;
            baud_ff <= 1'b0;
            mode_ff <= 1'b0;
        end
        else
        begin
            if (addr_load)
            begin
                addr_ff <= addr_value;
            end
            baud_ff <= baud_ff | baud_lock;
            mode_ff <= mode_ff | mode_lock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read response: data, data-check byte, then PEC
    tx_state_e tx_state_ff;
    logic [7:0] tx_crc_ff;
    logic fifo_valid;
    logic [FIFO_WIDTH-1:0] fifo_out;
    logic fifo_pop;
    logic up_fire;
    logic [7:0] check_byte;

    assign check_byte = 8'({rst_alert_ff, pec_alert_ff}) << CHECK_PEC_BIT;
    assign up_fire = link.up_valid && link.up_ready;
    assign fifo_pop = (tx_state_ff == TX_DATA) && link.up_ready;

    resp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(rsp_valid),
        .in_ready(rsp_ready),
        .in_data({rsp_last, rsp_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    always_comb
    begin
        link.up_valid = (tx_state_ff != TX_DATA) || fifo_valid;
        link.up_last = (tx_state_ff == TX_PEC);
        unique case (tx_state_ff)
            TX_DATA: link.up_data = fifo_out[BYTE_W-1:0];
            TX_CHECK: link.up_data = check_byte;
            default: link.up_data = tx_crc_ff;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_state_ff <= TX_DATA;
            tx_crc_ff <= CRC_INIT;
        end
        else if (up_fire)
        begin
            tx_crc_ff <= link.up_last ? CRC_INIT : crc_fold(tx_crc_ff, link.up_data);
            unique case (tx_state_ff)
                TX_DATA: tx_state_ff <= fifo_out[BYTE_W] ? TX_CHECK : TX_DATA;
                TX_CHECK: tx_state_ff <= TX_PEC;
                default: tx_state_ff <= TX_DATA;
            endcase
        end
    end

    assign device_addr = addr_ff;
    assign baud_detected = baud_ff;
    assign rx_mode_detected = mode_ff;
    assign pec_error_alert = pec_alert_ff;
    assign reset_occurred_alert = rst_alert_ff;
    assign check_done = done_ff;
    assign check_ok = ok_ff;
    assign wr_exec = wr_exec_ff;
    assign rd_req = rd_req_ff;
    assign cmd_code = cmd_ff;
    assign reg_addr = reg_ff;
    assign wr_data = data_ff;
endmodule

// >>> rtl/pec_host_end.sv
// Host end: sends commands with PEC, checks read packets.
// Assumes a valid/ready user side on sys_clk.
`timescale 1ns/1ps
module pec_host_end
(
    input wire logic sys_clk,
    input wire logic reset_n,
    pec_link_if.host link,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_alive,
    input wire logic cmd_last,
    input wire logic seed_en,
    input wire logic [7:0] seed_value,
    output logic cmd_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic rd_last,
    input wire logic rd_ready,
    output logic rd_err
);
    import pec_pkg::*;

    typedef enum logic {H_DATA, H_PEC} tx_state_e;
    typedef enum logic {R_COLLECT, R_REPLAY} rx_state_e;

    ////////////////////////////////////////////////////////////////////////
    // Command transmit with PEC appended
    tx_state_e tx_state_ff;
    logic first_ff;
    logic [7:0] crc_ff;
    logic dn_valid_ff;
    logic [7:0] dn_data_ff;
    logic dn_alive_ff;
    logic dn_last_ff;
    logic [7:0] crc_base;
    logic cmd_fire;

    assign cmd_ready = (tx_state_ff == H_DATA);
    assign cmd_fire = cmd_valid && cmd_ready;
    assign crc_base = first_ff ? (seed_en ? seed_value : CRC_INIT) : crc_ff;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_state_ff <= H_DATA;
            first_ff <= 1'b1;
            crc_ff <= CRC_INIT;
            {dn_valid_ff, dn_data_ff, dn_alive_ff, dn_last_ff} <= '0;
        end
        else
        begin
            dn_valid_ff <= 1'b0;
            dn_alive_ff <= 1'b0;
            dn_last_ff <= 1'b0;
            unique case (tx_state_ff)
                H_DATA:
                begin
                    if (cmd_fire)
                    begin
                        dn_valid_ff <= 1'b1;
                        dn_data_ff <= cmd_data;
                        dn_alive_ff <= cmd_alive;
                        first_ff <= 1'b0;
                        crc_ff <= cmd_alive ? crc_base : crc_fold(crc_base, cmd_data);
                        if (cmd_last)
                        begin
                            tx_state_ff <= H_PEC;
                        end
                    end
                end
                H_PEC:
                begin
                    dn_valid_ff <= 1'b1;
                    dn_data_ff <= crc_ff;
                    dn_last_ff <= 1'b1;
                    first_ff <= 1'b1;
                    tx_state_ff <= H_DATA;
                end
            endcase
        end
    end

    assign link.dn_valid = dn_valid_ff;
    assign link.dn_data = dn_data_ff;
    assign link.dn_alive = dn_alive_ff;
    assign link.dn_last = dn_last_ff;
    assign link.dn_char_err = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Read packet buffer, check, replay
    rx_state_e rx_state_ff;
    logic [7:0] buf_ff [HOST_BUF_DEPTH];
    logic [HOST_PTR_W-1:0] cnt_ff;
    logic [HOST_PTR_W-1:0] rptr_ff;
    logic [7:0] rx_crc_ff;
    logic overrun_ff;
    logic err_ff;
    logic up_fire;

    assign link.up_ready = (rx_state_ff == R_COLLECT);
    assign up_fire = link.up_valid && link.up_ready;

    always_ff @(posedge sys_clk)
    begin
        if (up_fire && !link.up_last && (cnt_ff < HOST_PTR_W'(HOST_BUF_DEPTH)))
        begin
            buf_ff[cnt_ff[HOST_PTR_W-2:0]] <= link.up_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_state_ff <= R_COLLECT;
            {cnt_ff, rptr_ff} <= '0;
            rx_crc_ff <= CRC_INIT;
            {overrun_ff, err_ff} <= '0;
        end
        else
        begin
            err_ff <= 1'b0;
            unique case (rx_state_ff)
                R_COLLECT:
                begin
                    if (up_fire && link.up_last)
                    begin
                        rx_crc_ff <= CRC_INIT;
                        overrun_ff <= 1'b0;
                        rptr_ff <= '0;
                        if ((link.up_data == rx_crc_ff) && !overrun_ff && (cnt_ff != '0))
                        begin
                            rx_state_ff <= R_REPLAY;
                        end
                        else
                        begin
                            err_ff <= 1'b1;
                            cnt_ff <= '0;
                        end
                    end
                    else if (up_fire)
                    begin
                        rx_crc_ff <= crc_fold(rx_crc_ff, link.up_data);
                        if (cnt_ff < HOST_PTR_W'(HOST_BUF_DEPTH))
                        begin
                            cnt_ff <= cnt_ff + 1'b1;
                        end
                        else
                        begin
                            overrun_ff <= 1'b1;
                        end
                    end
                end
                R_REPLAY:
                begin
                    if (rd_ready)
                    begin
                        rptr_ff <= rptr_ff + 1'b1;
                        if (rd_last)
                        begin
                            cnt_ff <= '0;
                            rx_state_ff <= R_COLLECT;
                        end
                    end
                end
            endcase
        end
    end

    assign rd_valid = (rx_state_ff == R_REPLAY);
    assign rd_data = buf_ff[rptr_ff[HOST_PTR_W-2:0]];
    assign rd_last = rd_valid && (rptr_ff == cnt_ff - 1'b1);
    assign rd_err = err_ff;
endmodule

// >>> sim/daisy_chain_packet_error_check_test.sv
// Bench: host and device ends, plus a device end driven directly.
// Assumes 50 MHz sys_clk and async reset_n.
`timescale 1ns/1ps
module daisy_chain_packet_error_check_test;
    import pec_pkg::*;
    logic sys_clk, reset_n, cmd_valid, cmd_alive, cmd_last, rd_ready, baud_lock, mode_lock, addr_load;
    logic clr_pec, clr_rst, rsp_valid, rsp_valid2, rsp_last, cmd_ready, rd_valid, rd_last, rd_err;
    logic [7:0] cmd_data, rsp_data, addr_value, rd_data, dev_addr, cmd_code, reg_addr;
    logic baud_det, mode_det, pec_al, rst_al, done, ok, wr_exec, rd_req, rsp_ready;
    logic pec_al2, done2, ok2, wr_exec2, rsp_ready2;
    logic [15:0] wr_data;
    int n_mismatch = 0, checks = 0, errs = 0;
    pec_link_if link();
    pec_link_if link2();
    pec_host_end pec_host_end_i(.sys_clk(sys_clk), .reset_n(reset_n), .link(link), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data), .cmd_alive(cmd_alive), .cmd_last(cmd_last), .seed_en(1'b0), .seed_value(8'h00),
        .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last), .rd_ready(rd_ready),
        .rd_err(rd_err));
    pec_device_end pec_device_end_i(.sys_clk(sys_clk), .reset_n(reset_n), .link(link), .baud_lock(baud_lock),
        .mode_lock(mode_lock), .addr_load(addr_load), .addr_value(addr_value), .clr_pec_alert(clr_pec),
        .clr_reset_alert(clr_rst), .device_addr(dev_addr), .baud_detected(baud_det), .rx_mode_detected(mode_det),
        .pec_error_alert(pec_al), .reset_occurred_alert(rst_al), .check_done(done), .check_ok(ok),
        .wr_exec(wr_exec), .rd_req(rd_req), .cmd_code(cmd_code), .reg_addr(reg_addr), .wr_data(wr_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready));
    pec_device_end pec_device_end_2_i(.sys_clk(sys_clk), .reset_n(reset_n), .link(link2), .baud_lock(baud_lock),
        .mode_lock(mode_lock), .addr_load(addr_load), .addr_value(addr_value), .clr_pec_alert(clr_pec),
        .clr_reset_alert(clr_rst), .device_addr(), .baud_detected(), .rx_mode_detected(),
        .pec_error_alert(pec_al2), .reset_occurred_alert(), .check_done(done2), .check_ok(ok2),
        .wr_exec(wr_exec2), .rd_req(), .cmd_code(), .reg_addr(), .wr_data(),
        .rsp_valid(rsp_valid2), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready2));
    pec_chk pec_chk_i(.sys_clk(sys_clk), .reset_n(reset_n), .dn_valid(link.dn_valid), .dn_data(link.dn_data),
        .dn_alive(link.dn_alive), .dn_last(link.dn_last), .dn_char_err(link.dn_char_err),
        .up_valid(link.up_valid), .up_ready(link.up_ready), .up_data(link.up_data), .up_last(link.up_last));
    ////////////////////////////////////////////////////////////////////////
    // Helpers
    initial
    begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (rd_err === 1'b1) errs++;
    function automatic logic [7:0] tcrc(input logic [7:0] c, input logic [7:0] d);
        c = c ^ d;
        repeat (8) c = c[0] ? ((c >> 1) ^ 8'hb2) : (c >> 1);
        return c;
    endfunction
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task complete_run();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task send(input logic [7:0] d, input logic alive, input logic last);
        @(posedge sys_clk);
        {cmd_valid, cmd_data, cmd_alive, cmd_last} <= {1'b1, d, alive, last};
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask
    task drv2(input logic [7:0] d, input logic last, input logic err);
        @(posedge sys_clk);
        {link2.dn_valid, link2.dn_data, link2.dn_last, link2.dn_char_err} <= {1'b1, d, last, err};
        @(posedge sys_clk);
        link2.dn_valid <= 1'b0;
    endtask
    task push(input logic [7:0] d, input logic last, input bit two);
        @(posedge sys_clk);
        {rsp_data, rsp_last} <= {d, last};
        if (two) rsp_valid2 <= 1'b1;
        else rsp_valid <= 1'b1;
        do @(posedge sys_clk); while ((two ? rsp_ready2 : rsp_ready) !== 1'b1);
        {rsp_valid, rsp_valid2} <= 2'b00;
    endtask
    task wait_done(input bit two);
        repeat (40)
        begin
            #1;
            if ((two ? done2 : done) === 1'b1) return;
            @(posedge sys_clk);
        end
        chk("check_done", 0, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset();
        #1 chk("addr", dev_addr, 0);
        chk("detect", {baud_det, mode_det}, 0);
        chk("rst_alert", rst_al, 1);
        @(posedge sys_clk);
        {baud_lock, mode_lock, addr_load, addr_value} <= {3'b111, 8'h2a};
        @(posedge sys_clk);
        {baud_lock, mode_lock, addr_load} <= 3'b000;
        @(posedge sys_clk);
        #1 chk("addr_set", {dev_addr, baud_det, mode_det}, {8'h2a, 2'b11});
        reset_n <= 1'b0;
        @(posedge sys_clk);
        #1 chk("addr_rst", {dev_addr, baud_det, mode_det, rst_al}, 1);
        @(posedge sys_clk);
        {reset_n, clr_rst} <= 2'b11;
        @(posedge sys_clk);
        clr_rst <= 1'b0;
        @(posedge sys_clk);
        #1 chk("rst_clear", rst_al, 0);
    endtask
    task t_write();
        logic [7:0] op[2];
        op = '{BROADCAST_WRITE_CMD, SINGLE_WRITE_CMD};
        foreach (op[i])
        begin
            send(op[i], 0, 0);
            send(8'h10, 0, 0);
            send(8'h34, 0, 0);
            send(8'h12, 0, 0);
            send(8'h77, 1, 1);
            wait_done(0);
            chk("wr_exec", {wr_exec, ok, pec_al}, 3'b110);
            chk("cmd", cmd_code, op[i]);
            chk("fields", {reg_addr, wr_data[7:0]}, 16'h1034);
            chk("data_hi", wr_data[15:8], 8'h12);
        end
    endtask
    task t_bad();
        logic [7:0] b[4], c;
        b = '{BROADCAST_WRITE_CMD, 8'h10, 8'h34, 8'h12};
        for (int k = 0; k < 3; k++)
        begin
            c = 8'h00;
            foreach (b[i])
            begin
                drv2(b[i], 0, k == 2 && i == 1);
                c = tcrc(c, b[i]);
            end
            drv2(k == 0 ? c ^ 8'h01 : c, 1, 0);
            wait_done(1);
            chk("wr_exec2", wr_exec2, k == 1);
            chk("pec_alert2", pec_al2, k < 2);
            chk("ok2", ok2, k == 1);
            clr_pec <= (k == 1);
            @(posedge sys_clk);
            clr_pec <= 1'b0;
        end
    endtask
    task t_read();
        logic [7:0] got[$];
        for (int i = 0; i < 2; i++)
        begin
            got = {};
            send(i ? SINGLE_DEVICE_READ_CMD : BROADCAST_READ_CMD, 0, 0);
            send(8'h10, 0, 1);
            wait_done(0);
            chk("rd_req", {rd_req, wr_exec}, 2'b10);
            push(8'h5a, 0, 0);
            push(8'hc3, 1, 0);
            repeat (60)
            begin
                @(posedge sys_clk);
                if (rd_valid === 1'b1) got.push_back(rd_data);
                if (rd_valid === 1'b1 && rd_last === 1'b1) break;
            end
            chk("rd_count", got.size(), 3);
            chk("rd_bytes", {got[0], got[1]}, 16'h5ac3);
            chk("data_check", got[2], 8'h00);
            chk("rd_err", errs, 0);
        end
    endtask
    task t_fill();
        logic [7:0] c, e;
        int n;
        for (int i = 0; i < 16; i++) push(8'h40 + i[7:0], i == 15, 1);
        @(posedge sys_clk);
        #1 chk("fifo_full", rsp_ready2, 0);
        {c, n} = 0;
        repeat (80)
        begin
            @(posedge sys_clk);
            if (link2.up_valid === 1'b1 && link2.up_ready === 1'b1)
            begin
                e = n < 16 ? 8'h40 + n[7:0] : (n == 16 ? 8'h00 : c);
                chk("up_byte", {link2.up_data, link2.up_last}, {e, n == 17});
                c = tcrc(c, e);
                n++;
            end
            link2.up_ready <= ~link2.up_ready;
        end
        chk("up_count", n, 18);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial
    begin
        {cmd_valid, cmd_alive, cmd_last, baud_lock, mode_lock, addr_load, clr_pec, clr_rst} = 0;
        {rsp_valid, rsp_valid2, rsp_last, cmd_data, rsp_data, addr_value} = 0;
        {link2.dn_valid, link2.dn_data, link2.dn_alive, link2.dn_last, link2.dn_char_err, link2.up_ready} = 0;
        rd_ready = 1'b1;
        reset_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_write();
        t_bad();
        t_read();
        t_fill();
        complete_run();
    end
    initial
    begin
        #(20 * 8000);
        n_mismatch++;
        complete_run();
    end
endmodule

// >>> sim/pec_chk.sv
// Assertions on the byte link between the two ends.
// Assumes one clock; the design drives every link signal.
`timescale 1ns/1ps
module pec_chk
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic dn_valid,
    input wire logic [7:0] dn_data,
    input wire logic dn_alive,
    input wire logic dn_last,
    input wire logic dn_char_err,
    input wire logic up_valid,
    input wire logic up_ready,
    input wire logic [7:0] up_data,
    input wire logic up_last
);
    function automatic logic [7:0] fold(input logic [7:0] c, input logic [7:0] d);
        c = c ^ d;
        repeat (8) c = c[0] ? ((c >> 1) ^ 8'hb2) : (c >> 1);
        return c;
    endfunction
    logic [7:0] dcrc_ff, dcnt_ff, ucrc_ff, ucnt_ff;
    logic up_hs;
    assign up_hs = up_valid && up_ready;
    ////////////////////////////////////////////////////////////////////////
    // Running check values of both directions
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {dcrc_ff, dcnt_ff, ucrc_ff, ucnt_ff} <= '0;
        end
        else
        begin
            if (dn_valid)
            begin
                dcrc_ff <= dn_last ? 8'h00 : (dn_alive ? dcrc_ff : fold(dcrc_ff, dn_data));
                dcnt_ff <= dn_last ? 8'h00 : dcnt_ff + {7'h00, !dn_alive};
            end
            if (up_hs)
            begin
                ucrc_ff <= up_last ? 8'h00 : fold(ucrc_ff, up_data);
                ucnt_ff <= up_last ? 8'h00 : ucnt_ff + 8'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    dn_pec_a: assert property (dn_valid && dn_last |-> dn_data == dcrc_ff)
        else $error("bad dn PEC");
    up_pec_a: assert property (up_hs && up_last |-> up_data == ucrc_ff)
        else $error("bad up PEC");
    char_err_a: assert property (dn_char_err == 1'b0)
        else $error("char error raised");
    pec_alone_a: assert property (dn_last |-> dn_valid && !dn_alive)
        else $error("PEC marked alive");
    pec_gap_a: assert property (dn_valid && dn_last |=> !dn_last)
        else $error("two check bytes in a row");
    dn_body_a: assert property (dn_valid && dn_last |-> dcnt_ff != 8'h00)
        else $error("empty packet");
    up_body_a: assert property (up_hs && up_last |-> ucnt_ff >= 8'h02)
        else $error("short response");
    up_hold_a: assert property (up_valid && !up_ready |=> up_valid && $stable(up_data) && $stable(up_last))
        else $error("stalled byte changed");
    cover property (dn_valid && dn_last);
    cover property (dn_valid && dn_alive);
    cover property (up_hs && up_last);
endmodule
